// ==== inc/clock_divider_control_pkg.sv ====
// package: register map, field layout, reset values and codes of the clock divider control
package clock_divider_control_pkg;
   // register map (offset of our own choosing)
   localparam logic [11:0] CLOCK_DIVIDER_CONTROL_ADDR = 12'h000;
   localparam int ADDR_W = 12;
   // field positions
   localparam int RECOVER_ON_INTERRUPT_BIT = 15;
   localparam int PERIPHERAL_RATIO_MSB = 14;
   localparam int PERIPHERAL_RATIO_LSB = 12;
   localparam int RATIO_ENABLE_BIT = 11;
   localparam int FAST_RC_POSTSCALE_MSB = 10;
   localparam int FAST_RC_POSTSCALE_LSB = 8;
   // reset values
   localparam logic RECOVER_ON_INTERRUPT_RST = 1'h0;
   localparam logic [2:0] PERIPHERAL_RATIO_RST = 3'h3;
   localparam logic RATIO_ENABLE_RST = 1'h0;
   localparam logic [2:0] FAST_RC_POSTSCALE_RST = 3'h1;
   // oscillator selection codes
   localparam logic [2:0] OSC_FAST_RC_A = 3'h7;
   localparam logic [2:0] OSC_FAST_RC_B = 3'h1;
   localparam logic [2:0] OSC_SLOW_500K = 3'h6;
   // postscaler division exponents for codes 6 and 7; codes 0..5 use the code itself
   localparam logic [3:0] POSTSCALE_SHIFT_6 = 4'h6;
   localparam logic [3:0] POSTSCALE_SHIFT_7 = 4'h8;
   localparam int DIV_W = 8;
   localparam logic [7:0] DIV_ZERO = 8'h00;
   localparam logic [7:0] DIV_ONE = 8'h01;
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;
   localparam logic [7:0] LOW_BYTE_ZERO = 8'h00;
   localparam logic [15:0] UPPER_ZERO = 16'h0000;
endpackage

// ==== src/clock_divider_peripheral_ratio_sel_control.sv ====
// clock divider control: divider register, peripheral ratio and fast rc postscaler enables

// Notes on behaviour
// - with recover-on-interrupt set, an interrupt clears ratio enable, ratio back to 1:1.
// - with recover-on-interrupt clear, interrupts change neither ratio enable nor ratio.
// - ratio field bits 14..12 selects processor-to-peripheral ratio 1:2^n, up to 1:128.
// - ratio field applies only while ratio enable bit 11 is set, else 1:1.
// - oscillator 111 or 001: fast rc divided by 1,2,4,8,16,32,64,256.
// - oscillator 110: the same divide ratios applied to the 500 kHz source.
// - postscaler field resets to 001, dividing the fast rc clock by two.
// - low byte of the divider register has no storage and reads zero.
module clock_divider_peripheral_ratio_sel_control (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic irq_event,
   input wire logic [2:0] current_osc_sel,
   input wire logic fast_rc_clk_in,
   input wire logic slow_500k_clk_in,
   output logic periph_clk_en,
   output logic [2:0] periph_ratio_active,
   output logic sys_clk_en,
   output logic postscale_active
);

   // ****************************************************************
   // bus decode
   // ****************************************************************

   // fields sit in byte lane 1; lane 0 is unimplemented
   wire logic hit;
   wire logic wr_access;
   wire logic rd_access;
   wire logic lane1_wr;
   assign hit = paddr[clock_divider_control_pkg::ADDR_W-1:0] == clock_divider_control_pkg::CLOCK_DIVIDER_CONTROL_ADDR
                && paddr[31:clock_divider_control_pkg::ADDR_W] == '0;
   assign wr_access = psel && !penable && pwrite && hit;
   assign rd_access = psel && !penable && !pwrite;
   assign lane1_wr = wr_access && pstrb[1];

   // ****************************************************************
   // divider register
   // ****************************************************************

   logic recover_on_interrupt_reg;
   logic [2:0] peripheral_ratio_sel_reg;
   logic ratio_enable_reg;
   logic [2:0] fast_rc_postscale_reg;
   logic ratio_enable_next;

   // hardware clear beats a write landing in the same cycle, so a late interrupt is never lost
   assign ratio_enable_next = (recover_on_interrupt_reg && irq_event) ? 1'b0 :
                              lane1_wr ? pwdata[clock_divider_control_pkg::RATIO_ENABLE_BIT] :
                              ratio_enable_reg;

   // writes take effect in setup so the access phase answers at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         recover_on_interrupt_reg <= clock_divider_control_pkg::RECOVER_ON_INTERRUPT_RST;
         peripheral_ratio_sel_reg <= clock_divider_control_pkg::PERIPHERAL_RATIO_RST;
         ratio_enable_reg <= clock_divider_control_pkg::RATIO_ENABLE_RST;
         fast_rc_postscale_reg <= clock_divider_control_pkg::FAST_RC_POSTSCALE_RST;
      end else begin
         ratio_enable_reg <= ratio_enable_next;
         if (lane1_wr) begin
            recover_on_interrupt_reg <= pwdata[clock_divider_control_pkg::RECOVER_ON_INTERRUPT_BIT];
            peripheral_ratio_sel_reg <= pwdata[clock_divider_control_pkg::PERIPHERAL_RATIO_MSB:clock_divider_control_pkg::PERIPHERAL_RATIO_LSB];
            fast_rc_postscale_reg <= pwdata[clock_divider_control_pkg::FAST_RC_POSTSCALE_MSB:clock_divider_control_pkg::FAST_RC_POSTSCALE_LSB];
         end
      end
   end

   // ****************************************************************
   // read path and bus answer
   // ****************************************************************

   wire logic [15:0] reg_image;
   assign reg_image = {recover_on_interrupt_reg, peripheral_ratio_sel_reg, ratio_enable_reg,
                       fast_rc_postscale_reg, clock_divider_control_pkg::LOW_BYTE_ZERO};

   // answer in the access phase: one wait-free cycle, error on unmapped address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= clock_divider_control_pkg::READ_ZERO;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata <= (rd_access && hit) ? {clock_divider_control_pkg::UPPER_ZERO, reg_image} : clock_divider_control_pkg::READ_ZERO;
         pready <= psel && !penable;
         pslverr <= psel && !penable && !hit;
      end
   end

   // ****************************************************************
   // ratio decode
   // ****************************************************************

   // shift amount of 2^n for a postscale code; code 6 gives 6, code 7 gives 8
   function automatic logic [3:0] postscale_shift(input logic [2:0] code);
      postscale_shift = (code == 3'h7) ? clock_divider_control_pkg::POSTSCALE_SHIFT_7 :
                        (code == 3'h6) ? clock_divider_control_pkg::POSTSCALE_SHIFT_6 : {1'b0, code};
   endfunction

   wire logic [2:0] ratio_eff;
   assign ratio_eff = ratio_enable_reg ? peripheral_ratio_sel_reg : 3'h0;

   // peripheral clock enable: one pulse every 2^n system cycles
   logic [7:0] periph_cnt_reg;
   wire logic [7:0] periph_top;
   wire logic periph_wrap;
   assign periph_top = 8'((9'h001 << ratio_eff) - 9'h001);
   assign periph_wrap = periph_cnt_reg >= periph_top;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         periph_cnt_reg <= clock_divider_control_pkg::DIV_ZERO;
         periph_clk_en <= 1'b0;
         periph_ratio_active <= 3'h0;
      end else begin
         periph_cnt_reg <= periph_wrap ? clock_divider_control_pkg::DIV_ZERO : periph_cnt_reg + clock_divider_control_pkg::DIV_ONE;
         periph_clk_en <= periph_wrap;
         periph_ratio_active <= ratio_eff;
      end
   end

   // ****************************************************************
   // fast rc postscaler
   // ****************************************************************

   // source edges are taken as synchronous; edge detect on the chosen source
   wire logic osc_fast;
   wire logic osc_slow;
   wire logic post_apply;
   wire logic src_level;
   logic src_d_reg;
   logic [7:0] post_cnt_reg;
   wire logic [7:0] post_top;
   wire logic src_edge;
   assign osc_fast = current_osc_sel == clock_divider_control_pkg::OSC_FAST_RC_A
                     || current_osc_sel == clock_divider_control_pkg::OSC_FAST_RC_B;
   assign osc_slow = current_osc_sel == clock_divider_control_pkg::OSC_SLOW_500K;
   assign post_apply = osc_fast || osc_slow;
   assign src_level = osc_slow ? slow_500k_clk_in : fast_rc_clk_in;
   assign src_edge = src_level && !src_d_reg;
   assign post_top = 8'((9'h001 << postscale_shift(fast_rc_postscale_reg)) - 9'h001);

   // limitation: undivided source must be slower than pclk/2 for its edges to be counted
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_d_reg <= 1'b0;
         post_cnt_reg <= clock_divider_control_pkg::DIV_ZERO;
         sys_clk_en <= 1'b0;
         postscale_active <= 1'b0;
      end else begin
         src_d_reg <= src_level;
         if (!post_apply) begin
            post_cnt_reg <= clock_divider_control_pkg::DIV_ZERO;
            sys_clk_en <= src_edge;
         end else if (src_edge) begin
            post_cnt_reg <= (post_cnt_reg >= post_top) ? clock_divider_control_pkg::DIV_ZERO : post_cnt_reg + clock_divider_control_pkg::DIV_ONE;
            sys_clk_en <= post_cnt_reg >= post_top;
         end else begin
            sys_clk_en <= 1'b0;
         end
         postscale_active <= post_apply;
      end
   end

endmodule

// ==== tb/clock_divider_control_props.sv ====
// checker: bus answer and clock enable relations of the clock divider control
module clock_divider_control_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [2:0] current_osc_sel,
   input wire logic periph_clk_en,
   input wire logic [2:0] periph_ratio_active,
   input wire logic postscale_active
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // bus answers: zero wait states, one pulse, quiet data outside answers
   property p_ans; psel && !penable |=> pready; endproperty
   a_ans: assert property (p_ans) else $error("no answer after setup");
   property p_one; pready |=> !pready; endproperty
   a_one: assert property (p_one) else $error("answer held too long");
   property p_idle; !pready |-> prdata == 32'h0000_0000; endproperty
   a_idle: assert property (p_idle) else $error("read data outside answer");
   property p_rsv; pready |-> prdata[7:0] == 8'h00 && prdata[31:16] == 16'h0000; endproperty
   a_rsv: assert property (p_rsv) else $error("unused bits not zero");
   property p_err; pready |-> pslverr == (paddr != 32'h0000_0000); endproperty
   a_err: assert property (p_err) else $error("error flag wrong");
   // clock enables against the selected source and ratio
   // gated on reset released at the start edge: the flag first updates one edge after release
   property p_osc; presetn |=> postscale_active == ($past(current_osc_sel) inside {3'h7, 3'h1, 3'h6}); endproperty
   a_osc: assert property (p_osc) else $error("postscale active wrong");
   property p_full; (periph_ratio_active == 3'h0) [*3] |-> periph_clk_en; endproperty
   a_full: assert property (p_full) else $error("pulse missing at 1:1");
   property p_gap; periph_clk_en && periph_ratio_active != 3'h0 ##1 $stable(periph_ratio_active) |-> !periph_clk_en;
   endproperty
   a_gap: assert property (p_gap) else $error("pulses too close");
endmodule
bind clock_divider_peripheral_ratio_sel_control clock_divider_control_props u_props (.pclk, .presetn, .psel, .penable, .paddr, .prdata, .pready,
   .pslverr, .current_osc_sel, .periph_clk_en, .periph_ratio_active, .postscale_active);

// ==== tb/tb_clock_divider_peripheral_ratio_sel_control.sv ====
// testbench: bus, interrupt recovery, ratio and postscaler of the clock divider control
module tb_clock_divider_peripheral_ratio_sel_control;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_event;
   logic periph_clk_en, sys_clk_en, postscale_active;
   logic [31:0] paddr, pwdata, prdata;
   logic [3:0] pstrb;
   logic [2:0] current_osc_sel, periph_ratio_active;
   logic [15:0] cyc, rnd;
   logic [33:0] note;
   logic [33:0] notes[$];
   logic [2:0] osc_tab[4] = '{3'h7, 3'h1, 3'h6, 3'h0};
   int n_fail, compares, cnt, tick;
   clock_divider_peripheral_ratio_sel_control DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
      .pready, .pslverr, .irq_event, .current_osc_sel, .fast_rc_clk_in(cyc[2]), .slow_500k_clk_in(cyc[3]),
      .periph_clk_en, .periph_ratio_active, .sys_clk_en, .postscale_active);
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic conclude();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // one transfer; note is {is read, error, data} for the watcher
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
      input logic [33:0] n);
      @(posedge pclk);
      notes.push_back(n);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic irq_pulse();
      irq_event <= 1'b1;
      @(posedge pclk);
      irq_event <= 1'b0;
   endtask
   // source levels far below pclk/2, and the hang limit
   always @(posedge pclk) begin
      cyc <= cyc + 16'h0001;
      tick <= tick + 1;
      if (tick == 60000) begin
         n_fail++;
         conclude();
      end
   end
   // answer watcher: oldest note against each bus answer
   always @(posedge pclk) begin
      if (pready === 1'b1) begin
         note = notes.pop_front();
         chk("pslverr", {31'h0, note[32]}, {31'h0, pslverr});
         if (note[33])
            chk("prdata", note[31:0], prdata);
      end
   end
   initial begin
      {presetn, psel, penable, pwrite, irq_event, pstrb} = 9'h000;
      {paddr, pwdata} = 64'h0;
      current_osc_sel = 3'h7;
      cyc = 16'h0000;
      tick = 0;
      rnd = lfsr(16'h000E);
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, 0, 0, 4'hf, {2'b10, 32'h0000_3100});
      apb(1, 0, 32'hFFFF_FFFF, 4'hf, 34'h0);
      apb(0, 0, 0, 4'hf, {2'b10, 32'h0000_FF00});
      irq_pulse();
      apb(0, 0, 0, 4'hf, {2'b10, 32'h0000_F700});
      chk("ratio", 32'h0, {29'h0, periph_ratio_active});
      apb(1, 0, {rnd, 1'b0, rnd[2:0], 1'b1, rnd[5:3], rnd[7:0]}, 4'hf, 34'h0);
      irq_pulse();
      apb(0, 32'h0000_0004, 0, 4'hf, {2'b11, 32'h0});
      apb(1, 32'h0000_0008, 32'hFFFF_FFFF, 4'hf, {2'b01, 32'h0});
      apb(1, 0, 0, 4'hd, 34'h0);
      apb(0, 0, 0, 4'hf, {2'b10, 17'h0, rnd[2:0], 1'b1, rnd[5:3], 8'h00});
      // every ratio code with enable set: exact pulse count in a window
      for (int n = 0; n < 8; n++) begin
         apb(1, 0, {17'h0, n[2:0], 1'b1, 11'h100}, 4'hf, 34'h0);
         repeat (260) @(posedge pclk);
         chk("ratio", {29'h0, n[2:0]}, {29'h0, periph_ratio_active});
         cnt = 0;
         repeat (256) @(posedge pclk) cnt += periph_clk_en;
         chk("periph pulses", 32'(256 >> n), 32'(cnt));
      end
      // every postscale code, cycling through fast, slow and other sources
      for (int k = 0; k < 8; k++) begin
         current_osc_sel <= osc_tab[k % 4];
         apb(1, 0, {21'h0, k[2:0], 8'h00}, 4'hf, 34'h0);
         repeat (1100) @(posedge pclk);
         chk("postscale active", {31'h0, k % 4 != 3}, {31'h0, postscale_active});
         cnt = 0;
         repeat (4096) @(posedge pclk) cnt += sys_clk_en;
         chk("sys pulses", 32'((k % 4 == 3) ? 512 : (k % 4 == 2 ? 256 : 512) >> k), 32'(cnt));
      end
      conclude();
   end
endmodule
